// >>> rtl/pcdas_map.svh
`ifndef PCDAS_MAP_SVH
`define PCDAS_MAP_SVH
// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define PCDAS_OFF_A_VALUE 8'h00
`define PCDAS_OFF_B_VALUE 8'h04
`define PCDAS_OFF_A_CHG_EN 8'h08
`define PCDAS_OFF_B_CHG_EN 8'h0c
`define PCDAS_OFF_B_ANSEL 8'h10
`define PCDAS_OFF_STATUS 8'h14
`define PCDAS_OFF_MASK 8'h18
// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define PCDAS_ANSEL_IMPL 8'h36
`define PCDAS_ANSEL_RST 8'h36
`define PCDAS_CHG_EN_RST 8'h00
`define PCDAS_FLAG_BIT 0
`define PCDAS_RESET_PIN_BIT 5
`endif

// >>> rtl/pcdas_pkg.sv
package pcdas_pkg;
	typedef logic [7:0] pcdas_byte_type;
	typedef logic [7:0] pcdas_addr_type;
endpackage

// >>> rtl/pcdas_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "pcdas_map.svh"
module pcdas_top (
	// apb
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// pins and device state
	input wire logic [7:0] first_port_pins,
	input wire logic [7:0] second_port_pins,
	input wire logic external_reset_pin_mode,
	input wire logic ext_pin_reset,
	input wire logic sleeping,
	// controls and events
	output logic [7:0] second_port_dig_in_en,
	output logic [7:0] second_port_pullup_allow,
	output logic irq,
	output logic wake
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	pcdas_pkg::pcdas_byte_type sa1_ff, sa2_ff, sb1_ff, sb2_ff;
	pcdas_pkg::pcdas_byte_type latch_a_ff, latch_b_ff;
	pcdas_pkg::pcdas_byte_type first_port_change_enable_ff;
	pcdas_pkg::pcdas_byte_type second_port_change_enable_ff;
	pcdas_pkg::pcdas_byte_type analog_select_bits_ff;
	logic shared_change_flag_ff, change_irq_enable_ff;
	logic [31:0] prdata_ff;
	logic pready_ff, pslverr_ff, irq_ff, wake_ff;
	pcdas_pkg::pcdas_byte_type dig_in_ff, pullup_ff;
	pcdas_pkg::pcdas_byte_type en_a, en_b, b_value;
	logic mismatch_any, wr_access, port_access, mapped, nxt_flag;

	function automatic logic is_mapped(input pcdas_pkg::pcdas_addr_type a);
		is_mapped = (a == `PCDAS_OFF_A_VALUE) || (a == `PCDAS_OFF_B_VALUE) ||
			(a == `PCDAS_OFF_A_CHG_EN) || (a == `PCDAS_OFF_B_CHG_EN) ||
			(a == `PCDAS_OFF_B_ANSEL) || (a == `PCDAS_OFF_STATUS) ||
			(a == `PCDAS_OFF_MASK);
	endfunction

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sa1_ff <= 8'h00;
			sa2_ff <= 8'h00;
			sb1_ff <= 8'h00;
			sb2_ff <= 8'h00;
		end else begin
			sa1_ff <= first_port_pins;
			sa2_ff <= sa1_ff;
			sb1_ff <= second_port_pins;
			sb2_ff <= sb1_ff;
		end
	end

	// ----------------------------------------
	// enables and mismatch
	// ----------------------------------------
	always_comb begin
		en_a = first_port_change_enable_ff;
		if (external_reset_pin_mode) begin
			en_a[`PCDAS_RESET_PIN_BIT] = 1'b0;
		end
		en_b = second_port_change_enable_ff & ~analog_select_bits_ff;
		b_value = sb2_ff & ~analog_select_bits_ff;
	end

	// one OR over both ports feeds the single flag
	assign mismatch_any = |((sa2_ff ^ latch_a_ff) & en_a) |
		|((sb2_ff ^ latch_b_ff) & en_b);
	assign mapped = is_mapped(paddr);
	assign wr_access = psel && penable && pready_ff && pwrite;
	assign port_access = psel && penable && pready_ff &&
		(paddr == `PCDAS_OFF_A_VALUE || paddr == `PCDAS_OFF_B_VALUE);

	// ----------------------------------------
	// last-read latch
	// ----------------------------------------
	// only the power-on reset touches it, never the pin reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			latch_a_ff <= 8'h00;
			latch_b_ff <= 8'h00;
		end else if (port_access) begin
			latch_a_ff <= sa2_ff;
			latch_b_ff <= b_value;
		end
	end

	// ----------------------------------------
	// configuration registers
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			first_port_change_enable_ff <= `PCDAS_CHG_EN_RST;
			second_port_change_enable_ff <= `PCDAS_CHG_EN_RST;
			analog_select_bits_ff <= `PCDAS_ANSEL_RST;
			change_irq_enable_ff <= 1'b0;
		end else if (ext_pin_reset) begin
			first_port_change_enable_ff <= `PCDAS_CHG_EN_RST;
			second_port_change_enable_ff <= `PCDAS_CHG_EN_RST;
			analog_select_bits_ff <= `PCDAS_ANSEL_RST;
			change_irq_enable_ff <= 1'b0;
		end else if (wr_access) begin
			case (paddr)
				`PCDAS_OFF_A_CHG_EN: first_port_change_enable_ff <= pwdata[7:0];
				`PCDAS_OFF_B_CHG_EN: second_port_change_enable_ff <= pwdata[7:0];
				`PCDAS_OFF_B_ANSEL: analog_select_bits_ff <= pwdata[7:0] & `PCDAS_ANSEL_IMPL;
				`PCDAS_OFF_MASK: change_irq_enable_ff <= pwdata[`PCDAS_FLAG_BIT];
				default: begin
				end
			endcase
		end
	end

	// ----------------------------------------
	// shared change flag
	// ----------------------------------------
	// a change landing on a port access may be lost: the latch refreshes
	always_comb begin
		nxt_flag = shared_change_flag_ff;
		if (wr_access && paddr == `PCDAS_OFF_STATUS && pwdata[`PCDAS_FLAG_BIT]) begin
			nxt_flag = 1'b0;
		end
		if (mismatch_any && !port_access) begin
			nxt_flag = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			shared_change_flag_ff <= 1'b0;
		end else if (ext_pin_reset) begin
			shared_change_flag_ff <= 1'b0;
		end else begin
			shared_change_flag_ff <= nxt_flag;
		end
	end

	// ----------------------------------------
	// interrupt, wake and pin controls
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_ff <= 1'b0;
			wake_ff <= 1'b0;
			dig_in_ff <= 8'h00;
			pullup_ff <= 8'h00;
		end else begin
			irq_ff <= shared_change_flag_ff && change_irq_enable_ff;
			wake_ff <= sleeping && shared_change_flag_ff && change_irq_enable_ff;
			dig_in_ff <= ~analog_select_bits_ff;
			pullup_ff <= ~analog_select_bits_ff;
		end
	end

	// ----------------------------------------
	// apb slave, zero wait states
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff <= 32'h0000_0000;
		end else begin
			pready_ff <= psel && !penable;
			pslverr_ff <= psel && !penable && !mapped;
			prdata_ff <= 32'h0000_0000;
			if (psel && !penable && !pwrite) begin
				case (paddr)
					`PCDAS_OFF_A_VALUE: prdata_ff <= {24'h00_0000, sa2_ff};
					`PCDAS_OFF_B_VALUE: prdata_ff <= {24'h00_0000, b_value};
					`PCDAS_OFF_A_CHG_EN: prdata_ff <= {24'h00_0000, first_port_change_enable_ff};
					`PCDAS_OFF_B_CHG_EN: prdata_ff <= {24'h00_0000, second_port_change_enable_ff};
					`PCDAS_OFF_B_ANSEL: prdata_ff <= {24'h00_0000, analog_select_bits_ff};
					`PCDAS_OFF_STATUS: prdata_ff <= {31'h0000_0000, shared_change_flag_ff};
					`PCDAS_OFF_MASK: prdata_ff <= {31'h0000_0000, change_irq_enable_ff};
					default: prdata_ff <= 32'h0000_0000;
				endcase
			end
		end
	end

	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
	assign irq = irq_ff;
	assign wake = wake_ff;
	assign second_port_dig_in_en = dig_in_ff;
	assign second_port_pullup_allow = pullup_ff;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	sequence mism_s;
		mismatch_any && !port_access && !ext_pin_reset;
	endsequence

	ansel_unimpl_a: assert property (@(posedge pclk) disable iff (!presetn)
		(analog_select_bits_ff & ~`PCDAS_ANSEL_IMPL) == 8'h00)
		else $error("unimplemented select bit set");
	ansel_write_a: assert property (@(posedge pclk) disable iff (!presetn)
		wr_access && paddr == `PCDAS_OFF_B_ANSEL && !ext_pin_reset |=>
		analog_select_bits_ff == ($past(pwdata[7:0]) & `PCDAS_ANSEL_IMPL))
		else $error("select write not taken");
	analog_off_a: assert property (@(posedge pclk) disable iff (!presetn)
		##1 ((dig_in_ff | pullup_ff) & $past(analog_select_bits_ff)) == 8'h00)
		else $error("analog pin still digital");
	reset_pin_a: assert property (@(posedge pclk) disable iff (!presetn)
		external_reset_pin_mode |-> !en_a[`PCDAS_RESET_PIN_BIT])
		else $error("reset pin detection active");
	flag_set_a: assert property (@(posedge pclk) disable iff (!presetn)
		mism_s |=> shared_change_flag_ff)
		else $error("mismatch did not set flag");
	set_wins_a: assert property (@(posedge pclk) disable iff (!presetn)
		mism_s and (wr_access && paddr == `PCDAS_OFF_STATUS) |=> shared_change_flag_ff)
		else $error("clear beat set");
	latch_take_a: assert property (@(posedge pclk) disable iff (!presetn)
		port_access |=> latch_a_ff == $past(sa2_ff) && latch_b_ff == $past(b_value))
		else $error("latch not refreshed");
	latch_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
		ext_pin_reset && !port_access |=> $stable(latch_a_ff) && $stable(latch_b_ff))
		else $error("latch lost on pin reset");
	irq_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
		shared_change_flag_ff && !change_irq_enable_ff |=> !irq_ff)
		else $error("irq raised while disabled");
	wake_a: assert property (@(posedge pclk) disable iff (!presetn)
		sleeping && shared_change_flag_ff && change_irq_enable_ff |=> wake_ff)
		else $error("no wake on change");

	// ----------------------------------------
	// flag, irq and pin-control checks
	// ----------------------------------------
	sequence clr_s;
		wr_access && paddr == `PCDAS_OFF_STATUS && pwdata[`PCDAS_FLAG_BIT] && !ext_pin_reset;
	endsequence

	sequence quiet_s;
		!mismatch_any && !ext_pin_reset;
	endsequence

	flag_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
		clr_s and quiet_s |=> !shared_change_flag_ff)
		else $error("flag clear not taken");
	flag_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		!shared_change_flag_ff && !mismatch_any |=> !shared_change_flag_ff)
		else $error("flag set without mismatch");
	flag_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
		shared_change_flag_ff && !ext_pin_reset && !(wr_access && paddr == `PCDAS_OFF_STATUS) |=>
		shared_change_flag_ff)
		else $error("flag dropped without clear");
	irq_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
		shared_change_flag_ff && change_irq_enable_ff |=> irq_ff)
		else $error("enabled flag gave no irq");
	irq_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
		!shared_change_flag_ff |=> !irq_ff)
		else $error("irq without flag");
	wake_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
		!sleeping |=> !wake_ff)
		else $error("wake while awake");
	analog_chg_a: assert property (@(posedge pclk) disable iff (!presetn)
		(en_b & analog_select_bits_ff) == 8'h00 && (b_value & analog_select_bits_ff) == 8'h00)
		else $error("analog pin still detected");
	pin_reset_a: assert property (@(posedge pclk) disable iff (!presetn)
		ext_pin_reset |=> !shared_change_flag_ff && !change_irq_enable_ff)
		else $error("pin reset left flag or enable");
	chg_en_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
		ext_pin_reset |=> first_port_change_enable_ff == `PCDAS_CHG_EN_RST &&
		second_port_change_enable_ff == `PCDAS_CHG_EN_RST)
		else $error("change enables survived reset");
	sync_pipe_a: assert property (@(posedge pclk) disable iff (!presetn)
		1'b1 |=> sa2_ff == $past(sa1_ff) && sb2_ff == $past(sb1_ff))
		else $error("pin sync stage skipped");
endmodule // pcdas_top
`default_nettype wire

// >>> dv/pcdas_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// external pin drivers
// ----------------------------------------
module pcdas_pin_model (
	// commanded levels
	input wire logic pclk,
	input wire logic [7:0] lvl_a,
	input wire logic [7:0] lvl_b,
	// pins
	output logic [7:0] first_port_pins,
	output logic [7:0] second_port_pins
);
	// pins only ever driven from outside, analog ones too
	always_ff @(posedge pclk) begin
		first_port_pins <= lvl_a;
		second_port_pins <= lvl_b;
	end
endmodule // pcdas_pin_model
`default_nettype wire

// >>> dv/port_change_detect_analog_select_test.sv
`timescale 1ns/1ps
`default_nettype none
module port_change_detect_analog_select_test;
	logic pclk, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic xmode = 1'b0, xrst = 1'b0, slp = 1'b0, pready, pslverr, irq, wake, se;
	logic [7:0] paddr = 8'h00, la = 8'h00, lb = 8'h00, pa, pb, din, pup;
	logic [31:0] pwdata = 32'h0, prdata, r;
	int err_count = 0, checks = 0;
	pcdas_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.first_port_pins(pa), .second_port_pins(pb), .external_reset_pin_mode(xmode),
		.ext_pin_reset(xrst), .sleeping(slp), .second_port_dig_in_en(din),
		.second_port_pullup_allow(pup), .irq(irq), .wake(wake));
	pcdas_pin_model u_pins (.pclk(pclk), .lvl_a(la), .lvl_b(lb), .first_port_pins(pa), .second_port_pins(pb));
	// ----------------------------------------
	// bus and compare helpers
	// ----------------------------------------
	task chk(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) begin
			err_count++;
			$display("[ERR] t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// no cycle count assumed: only the watchdog ends a hang
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		r = prdata;
		se = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// idle edge: a following call never re-drives psel in this step
		@(posedge pclk);
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		apb(1'b1, a, {24'h0, d});
	endtask
	task rd(input logic [7:0] a, input logic [7:0] e);
		apb(1'b0, a, 32'h0);
		chk(r, {24'h0, e});
	endtask
	// pin model, sync, flag and irq take five edges; six gives margin
	task settle;
		repeat (6) @(posedge pclk);
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task t_reset;
		rd(8'h08, 8'h00);
		rd(8'h0c, 8'h00);
		rd(8'h10, 8'h36);
		chk(din, 8'hc9);
		chk(pup, 8'hc9);
		$display("done reset");
	endtask
	task t_ansel;
		wr(8'h10, 8'hff);
		rd(8'h10, 8'h36);
		wr(8'h10, 8'h00);
		rd(8'h10, 8'h00);
		chk(din, 8'hff);
		chk(pup, 8'hff);
		wr(8'h10, 8'h36);
		$display("done ansel");
	endtask
	task t_change;
		wr(8'h18, 8'h01);
		wr(8'h08, 8'h01);
		rd(8'h00, 8'h00);
		la <= 8'h01;
		settle();
		rd(8'h14, 8'h01);
		chk(irq, 1'b1);
		wr(8'h14, 8'h01);
		rd(8'h14, 8'h01);
		rd(8'h00, 8'h01);
		wr(8'h14, 8'h01);
		rd(8'h14, 8'h00);
		chk(irq, 1'b0);
		$display("done change");
	endtask
	task t_mask;
		wr(8'h18, 8'h00);
		la <= 8'h00;
		settle();
		rd(8'h14, 8'h01);
		chk(irq, 1'b0);
		rd(8'h00, 8'h00);
		wr(8'h14, 8'h01);
		$display("done mask");
	endtask
	task t_analog;
		wr(8'h0c, 8'h02);
		lb <= 8'h02;
		settle();
		rd(8'h14, 8'h00);
		rd(8'h04, 8'h00);
		wr(8'h10, 8'h00);
		rd(8'h04, 8'h02);
		wr(8'h14, 8'h01);
		rd(8'h14, 8'h00);
		lb <= 8'h00;
		settle();
		rd(8'h14, 8'h01);
		rd(8'h04, 8'h00);
		wr(8'h14, 8'h01);
		wr(8'h10, 8'h36);
		$display("done analog");
	endtask
	task t_rstpin;
		xmode <= 1'b1;
		wr(8'h08, 8'h20);
		la <= 8'h20;
		settle();
		rd(8'h14, 8'h00);
		xmode <= 1'b0;
		settle();
		rd(8'h14, 8'h01);
		rd(8'h00, 8'h20);
		wr(8'h14, 8'h01);
		rd(8'h14, 8'h00);
		// latch differs from the new pin level, so a wiped latch would hide the change
		la <= 8'h00;
		xrst <= 1'b1;
		repeat (2) @(posedge pclk);
		xrst <= 1'b0;
		@(posedge pclk);
		wr(8'h08, 8'h20);
		settle();
		rd(8'h14, 8'h01);
		rd(8'h00, 8'h00);
		wr(8'h14, 8'h01);
		rd(8'h14, 8'h00);
		$display("done rstpin");
	endtask
	task t_wake;
		wr(8'h18, 8'h01);
		slp <= 1'b1;
		wr(8'h08, 8'h01);
		la <= 8'h21;
		settle();
		chk(wake, 1'b1);
		slp <= 1'b0;
		rd(8'h00, 8'h21);
		chk(wake, 1'b0);
		wr(8'h14, 8'h01);
		apb(1'b0, 8'h1c, 32'h0);
		chk(se, 1'b1);
		chk(r, 32'h0);
		$display("done wake");
	endtask
	// ----------------------------------------
	// run control
	// ----------------------------------------
	task conclude;
		$display("checks %0d errors %0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	initial begin
		repeat (20000) @(posedge pclk);
		err_count++;
		conclude();
	end
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_reset();
		t_ansel();
		t_change();
		t_mask();
		t_analog();
		t_rstpin();
		t_wake();
		conclude();
	end
endmodule // port_change_detect_analog_select_test
`default_nettype wire
